// >>> inc/lpmcg_pkg.sv
// Constants and types of the operating-mode clock gating controller
`default_nettype none
package lpmcg_pkg;

  typedef enum logic [2:0] {
    LPMCG_RUN   = 3'b000,
    LPMCG_SL0   = 3'b001,
    LPMCG_SL1   = 3'b010,
    LPMCG_SL2   = 3'b011,
    LPMCG_SL3   = 3'b100,
    LPMCG_SL4   = 3'b101,
    LPMCG_SL5   = 3'b110
  } lpmcg_mode_t;

  typedef enum logic [1:0] {
    LPMCG_SRC_SLOW = 2'b00,
    LPMCG_SRC_FAST = 2'b01,
    LPMCG_SRC_EXT  = 2'b10
  } lpmcg_src_t;

  // Power and oscillator controls derived from the effective mode
  typedef struct packed {
    logic cpu_off;
    logic core_pwr;
    logic fast_osc_en;
    logic slow_osc_en;
    logic [1:0] aclk_src;
    logic [1:0] sub_clk_src;
  } lpmcg_ctl_t;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int RET_BYTES = 8;

  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_RET0 = 8'h10;
  localparam logic [7:0] OFS_RET1 = 8'h14;

  // Control register fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_ASRC_LSB = 4;
  localparam int CTRL_SSRC_LSB = 6;

  // Status register fields
  localparam int STAT_MODE_LSB = 0;
  localparam int STAT_AWAKE = 3;
  localparam int STAT_MCLK = 4;
  localparam int STAT_SUBCLK = 5;
  localparam int STAT_ACLK = 6;
  localparam int STAT_PWR = 7;
  localparam int STAT_PIN = 8;

  localparam logic [2:0] RST_MODE = 3'h0;
  localparam logic [1:0] RST_SRC = 2'h0;
  localparam logic [7:0] RST_RET = 8'h00;

endpackage
`default_nettype wire

// >>> hw/lpmcg_ctrl.sv
// Operating-mode controller driving clock gates and power switches
`timescale 1ns/100ps
`default_nettype none
module lpmcg_ctrl (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [lpmcg_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [lpmcg_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [lpmcg_pkg::DATA_W-1:0] reg_rdata,
  input wire logic irq_req,
  input wire logic irq_return,
  input wire logic deep_sleep_pin,
  input wire logic mclk_lvl,
  input wire logic subsystem_clock_lvl,
  input wire logic aclk_lvl,
  output logic cpu_off,
  output logic mclk_en,
  output logic subsystem_clock_en,
  output logic aclk_en,
  output logic [1:0] aclk_src,
  output logic [1:0] subsystem_clock_src,
  output logic fast_oscillator_en,
  output logic slow_oscillator_en,
  output logic osc_1k_en,
  output logic core_pwr_en,
  output logic retention_pwr_en
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [1:0] remap_src(input logic [2:0] mode,
                                           input logic [1:0] src);
    logic lowonly;
    lowonly = (mode == lpmcg_pkg::LPMCG_SL1) ||
              (mode == lpmcg_pkg::LPMCG_SL3);
    if (lowonly && src == lpmcg_pkg::LPMCG_SRC_FAST) begin
      remap_src = lpmcg_pkg::LPMCG_SRC_SLOW;
    end else begin
      remap_src = src;
    end
  endfunction

  function automatic logic valid_mode(input logic [2:0] m);
    valid_mode = (m <= lpmcg_pkg::LPMCG_SL5);
  endfunction

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [2:0] sel_mode_reg;
  logic [1:0] asrc_reg;
  logic [1:0] ssrc_reg;
  logic awake_reg;
  logic awake_next;
  logic [2:0] eff_mode_reg;
  logic [2:0] eff_mode_next;
  lpmcg_pkg::lpmcg_ctl_t ctl_reg;
  lpmcg_pkg::lpmcg_ctl_t ctl_next;
  logic mclk_en_reg;
  logic sub_clk_en_reg;
  logic aclk_en_reg;
  logic [lpmcg_pkg::DATA_W-1:0] rdata_reg;
  logic [lpmcg_pkg::DATA_W-1:0] rdata_next;
  logic [7:0] ret_mem [lpmcg_pkg::RET_BYTES];

  wire wr_ctrl = reg_wr && (reg_addr == lpmcg_pkg::OFS_CTRL);
  wire wr_ret0 = reg_wr && (reg_addr == lpmcg_pkg::OFS_RET0);
  wire wr_ret1 = reg_wr && (reg_addr == lpmcg_pkg::OFS_RET1);
  wire [2:0] wr_mode = reg_wdata[lpmcg_pkg::CTRL_MODE_LSB +: 3];
  wire sleeping = (sel_mode_reg != lpmcg_pkg::LPMCG_RUN);

  // ---------------------------------------------------------------
  // Mode selection and wake
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sel_mode_reg <= lpmcg_pkg::RST_MODE;
      asrc_reg <= lpmcg_pkg::RST_SRC;
      ssrc_reg <= lpmcg_pkg::RST_SRC;
    end else if (wr_ctrl) begin
      if (valid_mode(wr_mode)) begin
        sel_mode_reg <= wr_mode;
      end
      asrc_reg <= reg_wdata[lpmcg_pkg::CTRL_ASRC_LSB +: 2];
      ssrc_reg <= reg_wdata[lpmcg_pkg::CTRL_SSRC_LSB +: 2];
    end
  end

  // Wake holds until interrupt return; a new request while sleeping wins the clear
  assign awake_next = (irq_req && sleeping) ? 1'b1 :
                      irq_return ? 1'b0 : awake_reg;

  // Level five only while the activation pin allows it
  assign eff_mode_next = awake_reg ? lpmcg_pkg::LPMCG_RUN :
    (sel_mode_reg == lpmcg_pkg::LPMCG_SL5 && !deep_sleep_pin) ?
      lpmcg_pkg::LPMCG_SL4 : sel_mode_reg;

  // ---------------------------------------------------------------
  // Power and oscillator decode
  // ---------------------------------------------------------------
  logic aclk_want;
  logic sub_clk_want;
  logic mclk_want;
  logic [1:0] asrc_eff;
  logic [1:0] ssrc_eff;
  assign mclk_want = (eff_mode_next == lpmcg_pkg::LPMCG_RUN);
  assign sub_clk_want = (eff_mode_next <= lpmcg_pkg::LPMCG_SL1);
  assign aclk_want = (eff_mode_next <= lpmcg_pkg::LPMCG_SL3);
  assign asrc_eff = remap_src(eff_mode_next, asrc_reg);
  assign ssrc_eff = remap_src(eff_mode_next, ssrc_reg);

  always_comb begin
    ctl_next.cpu_off = (eff_mode_next != lpmcg_pkg::LPMCG_RUN);
    ctl_next.core_pwr = (eff_mode_next != lpmcg_pkg::LPMCG_SL5);
    ctl_next.aclk_src = asrc_eff;
    ctl_next.sub_clk_src = ssrc_eff;
    // Oscillators run only for a clock that is wanted
    ctl_next.fast_osc_en = mclk_want ||
      (aclk_want && asrc_eff == lpmcg_pkg::LPMCG_SRC_FAST) ||
      (sub_clk_want && ssrc_eff == lpmcg_pkg::LPMCG_SRC_FAST);
    ctl_next.slow_osc_en =
      (aclk_want && asrc_eff == lpmcg_pkg::LPMCG_SRC_SLOW) ||
      (sub_clk_want && ssrc_eff == lpmcg_pkg::LPMCG_SRC_SLOW);
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      awake_reg <= 1'b0;
      eff_mode_reg <= lpmcg_pkg::RST_MODE;
      ctl_reg <= '{1'b0, 1'b1, 1'b1, 1'b1, 2'h0, 2'h0};
    end else begin
      awake_reg <= awake_next;
      eff_mode_reg <= eff_mode_next;
      ctl_reg <= ctl_next;
    end
  end

  // ---------------------------------------------------------------
  // Glitch-free gates: change only while the clock sits low
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mclk_en_reg <= 1'b1;
      sub_clk_en_reg <= 1'b1;
      aclk_en_reg <= 1'b1;
    end else begin
      if (!mclk_lvl) mclk_en_reg <= mclk_want;
      if (!subsystem_clock_lvl) sub_clk_en_reg <= sub_clk_want;
      if (!aclk_lvl) aclk_en_reg <= aclk_want;
    end
  end

  // ---------------------------------------------------------------
  // Retention RAM, always powered, cleared only by reset
  // ---------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < lpmcg_pkg::RET_BYTES; gi++) begin : g_ret
      localparam int WORD = gi / 4;
      localparam int LANE = gi % 4;
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          ret_mem[gi] <= lpmcg_pkg::RST_RET;
        end else if ((WORD == 0) ? wr_ret0 : wr_ret1) begin
          ret_mem[gi] <= reg_wdata[LANE*8 +: 8];
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Register read
  // ---------------------------------------------------------------
  always_comb begin
    rdata_next = '0;
    if (!reg_rd) begin
      rdata_next = '0;
    end else if (reg_addr == lpmcg_pkg::OFS_CTRL) begin
      rdata_next[lpmcg_pkg::CTRL_MODE_LSB +: 3] = sel_mode_reg;
      rdata_next[lpmcg_pkg::CTRL_ASRC_LSB +: 2] = asrc_reg;
      rdata_next[lpmcg_pkg::CTRL_SSRC_LSB +: 2] = ssrc_reg;
    end else if (reg_addr == lpmcg_pkg::OFS_STATUS) begin
      rdata_next[lpmcg_pkg::STAT_MODE_LSB +: 3] = eff_mode_reg;
      rdata_next[lpmcg_pkg::STAT_AWAKE] = awake_reg;
      rdata_next[lpmcg_pkg::STAT_MCLK] = mclk_en_reg;
      rdata_next[lpmcg_pkg::STAT_SUBCLK] = sub_clk_en_reg;
      rdata_next[lpmcg_pkg::STAT_ACLK] = aclk_en_reg;
      rdata_next[lpmcg_pkg::STAT_PWR] = ctl_reg.core_pwr;
      rdata_next[lpmcg_pkg::STAT_PIN] = deep_sleep_pin;
    end else if (reg_addr == lpmcg_pkg::OFS_RET0) begin
      rdata_next = {ret_mem[3], ret_mem[2], ret_mem[1], ret_mem[0]};
    end else if (reg_addr == lpmcg_pkg::OFS_RET1) begin
      rdata_next = {ret_mem[7], ret_mem[6], ret_mem[5], ret_mem[4]};
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign reg_rdata = rdata_reg;
  assign cpu_off = ctl_reg.cpu_off;
  assign core_pwr_en = ctl_reg.core_pwr;
  assign fast_oscillator_en = ctl_reg.fast_osc_en;
  assign slow_oscillator_en = ctl_reg.slow_osc_en;
  assign aclk_src = ctl_reg.aclk_src;
  assign subsystem_clock_src = ctl_reg.sub_clk_src;
  assign mclk_en = mclk_en_reg;
  assign subsystem_clock_en = sub_clk_en_reg;
  assign aclk_en = aclk_en_reg;
  assign osc_1k_en = 1'b1;
  assign retention_pwr_en = 1'b1;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  property p_mode_write;
    @(posedge clk_sys) disable iff (rst)
    wr_ctrl && valid_mode(wr_mode) |=> sel_mode_reg == $past(wr_mode);
  endproperty
  a_mode_write: assert property (p_mode_write)
    else $error("selected mode not taken from write");

  property p_wake;
    @(posedge clk_sys) disable iff (rst)
    irq_req && sleeping |=> awake_reg ##1 !cpu_off;
  endproperty
  a_wake: assert property (p_wake)
    else $error("interrupt did not wake processor");

  property p_return;
    @(posedge clk_sys) disable iff (rst)
    awake_reg && irq_return && !irq_req |=> ##1
      eff_mode_reg == $past(sel_mode_reg, 2) || !sleeping ||
      sel_mode_reg == lpmcg_pkg::LPMCG_SL5;
  endproperty
  a_return: assert property (p_return)
    else $error("selected level not re-entered");

  property p_run_clocks;
    @(posedge clk_sys) disable iff (rst)
    mclk_want && !mclk_lvl && !aclk_lvl && !subsystem_clock_lvl
      |=> mclk_en && aclk_en && subsystem_clock_en;
  endproperty
  a_run_clocks: assert property (p_run_clocks)
    else $error("clock stopped in run state");

  property p_level0;
    @(posedge clk_sys) disable iff (rst)
    eff_mode_next == lpmcg_pkg::LPMCG_SL0 && !mclk_lvl && !aclk_lvl
      |=> cpu_off && !mclk_en && aclk_en;
  endproperty
  a_level0: assert property (p_level0)
    else $error("level zero gating wrong");

  property p_remap;
    @(posedge clk_sys) disable iff (rst)
    (eff_mode_next == lpmcg_pkg::LPMCG_SL1 ||
     eff_mode_next == lpmcg_pkg::LPMCG_SL3) &&
    asrc_reg == lpmcg_pkg::LPMCG_SRC_FAST
      |=> aclk_src == lpmcg_pkg::LPMCG_SRC_SLOW;
  endproperty
  a_remap: assert property (p_remap)
    else $error("fast source not remapped to slow");

  property p_level2;
    @(posedge clk_sys) disable iff (rst)
    eff_mode_next == lpmcg_pkg::LPMCG_SL2 && !subsystem_clock_lvl
      |=> !subsystem_clock_en && cpu_off;
  endproperty
  a_level2: assert property (p_level2)
    else $error("subsystem clock running in level two");

  property p_level4;
    @(posedge clk_sys) disable iff (rst)
    eff_mode_next == lpmcg_pkg::LPMCG_SL4 |=>
      !fast_oscillator_en && !slow_oscillator_en && osc_1k_en;
  endproperty
  a_level4: assert property (p_level4)
    else $error("oscillator running in level four");

  property p_power;
    @(posedge clk_sys) disable iff (rst)
    !core_pwr_en |-> eff_mode_reg == lpmcg_pkg::LPMCG_SL5 &&
      retention_pwr_en && $past(deep_sleep_pin);
  endproperty
  a_power: assert property (p_power)
    else $error("core power removed outside level five");

  property p_gate_low;
    @(posedge clk_sys) disable iff (rst)
    $changed(mclk_en) || $changed(aclk_en) || $changed(subsystem_clock_en)
      |-> (!$past(mclk_lvl) || !$changed(mclk_en)) &&
      (!$past(subsystem_clock_lvl) || !$changed(subsystem_clock_en)) &&
      (!$past(aclk_lvl) || !$changed(aclk_en));
  endproperty
  a_gate_low: assert property (p_gate_low)
    else $error("clock gate switched while clock high");

endmodule
`default_nettype wire

// >>> test/lpmcg_clk_model.sv
// Behavioural model of the oscillators behind the clock gates
`timescale 1ns/100ps
`default_nettype none
module lpmcg_clk_model (
  input wire logic clk_sys,
  input wire logic rst,
  output logic mclk_lvl,
  output logic subsystem_clock_lvl,
  output logic aclk_lvl
);
  logic [2:0] div_reg;
  // Three rates, so each gate waits for its own low phase
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      div_reg <= 3'h0;
    end else begin
      div_reg <= div_reg + 3'h1;
    end
  end
  assign mclk_lvl = div_reg[0];
  assign subsystem_clock_lvl = div_reg[1];
  assign aclk_lvl = div_reg[2];
endmodule
`default_nettype wire

// >>> test/tb_low_power_mode_clock_gating.sv
// Self-checking bench of the operating-mode clock gating controller
`timescale 1ns/100ps
`default_nettype none
module tb_low_power_mode_clock_gating;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic irq_req = 1'b0;
  logic irq_return = 1'b0;
  logic deep_sleep_pin = 1'b0;
  logic mclk_lvl, subsystem_clock_lvl, aclk_lvl;
  logic cpu_off, mclk_en, subsystem_clock_en, aclk_en;
  logic [1:0] aclk_src, subsystem_clock_src;
  logic fast_oscillator_en, slow_oscillator_en, osc_1k_en;
  logic core_pwr_en, retention_pwr_en;
  logic [31:0] rv;
  logic [2:0] en_prev = 3'h7;
  logic [2:0] lvl_prev = 3'h0;
  int fail_count = 0;
  int check_count = 0;
  int cycles = 0;

  always #5 clk_sys = ~clk_sys;

  lpmcg_clk_model clk_u (.clk_sys(clk_sys), .rst(rst), .mclk_lvl(mclk_lvl),
    .subsystem_clock_lvl(subsystem_clock_lvl), .aclk_lvl(aclk_lvl));

  lpmcg_ctrl dut_u (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq_req(irq_req), .irq_return(irq_return),
    .deep_sleep_pin(deep_sleep_pin), .mclk_lvl(mclk_lvl),
    .subsystem_clock_lvl(subsystem_clock_lvl), .aclk_lvl(aclk_lvl),
    .cpu_off(cpu_off), .mclk_en(mclk_en),
    .subsystem_clock_en(subsystem_clock_en), .aclk_en(aclk_en),
    .aclk_src(aclk_src), .subsystem_clock_src(subsystem_clock_src),
    .fast_oscillator_en(fast_oscillator_en),
    .slow_oscillator_en(slow_oscillator_en), .osc_1k_en(osc_1k_en),
    .core_pwr_en(core_pwr_en), .retention_pwr_en(retention_pwr_en));

  task automatic conclude();
    $display("Checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: word %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic settle();
    repeat (20) @(posedge clk_sys);
    #1;
  endtask

  task automatic set_mode(input logic [2:0] m, input logic [1:0] a,
                          input logic [1:0] s);
    wr_reg(lpmcg_pkg::OFS_CTRL, {24'h0, s, a, 1'b0, m});
    settle();
  endtask

  // One-cycle interrupt request, or interrupt return when ret is set
  task automatic pulse(input logic ret);
    @(posedge clk_sys);
    if (ret) begin
      irq_return <= 1'b1;
    end else begin
      irq_req <= 1'b1;
    end
    @(posedge clk_sys);
    irq_return <= 1'b0;
    irq_req <= 1'b0;
    settle();
  endtask

  // Expected {cpu_off, main, subsystem, auxiliary, fast oscillator}
  function automatic logic [4:0] exp_state(input logic [2:0] m);
    case (m)
      3'h0: exp_state = 5'h0F;
      3'h1: exp_state = 5'h17;
      3'h2: exp_state = 5'h16;
      3'h3: exp_state = 5'h13;
      3'h4: exp_state = 5'h12;
      default: exp_state = 5'h10;
    endcase
  endfunction

  task automatic test_modes();
    logic [4:0] e;
    logic slow_map;
    for (int i = 0; i < 6; i++) begin
      e = exp_state(3'(i));
      slow_map = (i == 2) || (i == 4);
      set_mode(3'(i), 2'h1, 2'h1);
      chk_word({27'h0, cpu_off, mclk_en, subsystem_clock_en, aclk_en,
        fast_oscillator_en}, {27'h0, e});
      if (e[1]) chk_word({30'h0, aclk_src}, {31'h0, !slow_map});
      if (e[2]) chk_word({30'h0, subsystem_clock_src}, {31'h0, !slow_map});
      chk_bit(osc_1k_en, 1'b1);
    end
    chk_bit(slow_oscillator_en, 1'b0);
    set_mode(3'h2, 2'h2, 2'h2);
    chk_word({28'h0, aclk_src, subsystem_clock_src}, 32'h0000000A);
    set_mode(3'h4, 2'h2, 2'h1);
    chk_word({30'h0, aclk_src}, 32'h2);
  endtask

  task automatic test_deep_sleep();
    wr_reg(lpmcg_pkg::OFS_RET0, 32'h89ABCDEF);
    wr_reg(lpmcg_pkg::OFS_RET1, 32'h01234567);
    set_mode(3'h6, 2'h1, 2'h1);
    chk_word({30'h0, core_pwr_en, aclk_en}, 32'h2);
    @(posedge clk_sys);
    deep_sleep_pin <= 1'b1;
    settle();
    chk_word({29'h0, core_pwr_en, osc_1k_en, retention_pwr_en}, 32'h3);
    rd_reg(lpmcg_pkg::OFS_STATUS, rv);
    chk_word({27'h0, rv[8], rv[7], rv[2:0]}, 32'h16);
    @(posedge clk_sys);
    deep_sleep_pin <= 1'b0;
    set_mode(3'h0, 2'h0, 2'h0);
    chk_word({30'h0, core_pwr_en, slow_oscillator_en}, 32'h3);
    rd_reg(lpmcg_pkg::OFS_RET0, rv);
    chk_word(rv, 32'h89ABCDEF);
    rd_reg(lpmcg_pkg::OFS_RET1, rv);
    chk_word(rv, 32'h01234567);
  endtask

  task automatic test_wake();
    set_mode(3'h4, 2'h1, 2'h1);
    pulse(1'b0);
    chk_word({30'h0, cpu_off, aclk_src[0]}, 32'h1);
    rd_reg(lpmcg_pkg::OFS_STATUS, rv);
    chk_word({28'h0, rv[6:3]}, 32'hF);
    pulse(1'b1);
    chk_word({28'h0, cpu_off, mclk_en, aclk_src}, 32'h8);
    set_mode(3'h0, 2'h1, 2'h1);
    pulse(1'b0);
    rd_reg(lpmcg_pkg::OFS_STATUS, rv);
    chk_word({30'h0, rv[3], cpu_off}, 32'h0);
  endtask

  task automatic test_refusals();
    set_mode(3'h3, 2'h0, 2'h0);
    wr_reg(lpmcg_pkg::OFS_CTRL, 32'h00000007);
    rd_reg(lpmcg_pkg::OFS_STATUS, rv);
    chk_word({29'h0, rv[2:0]}, 32'h3);
    rd_reg(8'h08, rv);
    chk_word(rv, 32'h0);
  endtask

  // Gate enables may only change after a low clock sample
  always @(posedge clk_sys) begin
    if (!rst && ((({mclk_en, subsystem_clock_en, aclk_en} ^ en_prev)
        & lvl_prev) != 3'h0)) begin
      fail_count++;
      $display("Error at %0t: gate switched while clock high", $time);
    end
    en_prev = {mclk_en, subsystem_clock_en, aclk_en};
    lvl_prev = {mclk_lvl, subsystem_clock_lvl, aclk_lvl};
  end

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      $display("Error at %0t: run did not finish", $time);
      conclude();
    end
  end

  initial begin
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    #1;
    chk_word({26'h0, cpu_off, mclk_en, subsystem_clock_en, aclk_en,
      core_pwr_en, osc_1k_en}, 32'h1F);
    test_modes();
    test_deep_sleep();
    test_wake();
    test_refusals();
    conclude();
  end
endmodule
`default_nettype wire
